// >>> lnw_port.sv
// Functional notes
// (RULE1) Sixteen x4 ports, pairs mergeable to x8.
// (RULE2) Ports default x4, lanes fixed per port.
// (RULE3) Check TS symbols 6-15, invert lane data.
// (RULE4) Transmit data is never inverted.
// (RULE5) Polarity state is kept per lane.
// (RULE6) Max width: min of cap and lanes.
// (RULE7) Lane reversal follows the max width.
// (RULE8) Cap field writable only when unlocked.
// (RULE9) New cap applies at next full training.
// (RULE10) x8 port negotiates x8, x4, x2, x1.
// (RULE11) Status reports negotiated lane count.
// (RULE12) Full retrain bit forces retrain via Detect.
// (RULE13) Downstream port tries reversal for wider link.
// (RULE14) Accept partner's narrower supported configuration.
// (RULE15) Lane-number failure: retrain, no reversal.
// (RULE16) Honour partner width up/down requests.
// (RULE17) Only reliability downsizing is self-started.
// (RULE18) Autonomous width disable reads zero.
// (RULE19) Transmit autonomous-change indication always clear.
// (RULE20) Flag partner autonomous width change downstream.
// (RULE21) Up/downstream behaviour follows operating state.
// (RULE22) Reversed lane i maps to W-1-i.
//
// The address map and the address-and-strobe port were left to the implementer.
`default_nettype none
module lnw_port (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_b_i, // Async reset, active low
    input wire lnw_pkg::lnw_addr_t reg_addr_i, // Register byte address
    input wire logic [31:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
    input wire logic [lnw_pkg::LNW_LANES-1:0][7:0] rx_sym_i, // Per-lane received symbols
    input wire logic [3:0] rx_sym_idx_i, // Symbol index within the set
    input wire logic rx_ts2_i, // Current set is TS2
    input wire logic [lnw_pkg::LNW_LANES-1:0] rx_ts_valid_i, // Symbol is part of a set
    input wire logic training_i, // LTSSM is training
    output logic [lnw_pkg::LNW_LANES-1:0][7:0] rx_data_o, // Polarity-corrected data
    output logic [lnw_pkg::LNW_LANES-1:0] rx_inv_o, // Per-lane inversion
    input wire logic op_downstream_i, // Operating state is downstream
    input wire logic detect_entry_i, // LTSSM entered Detect
    input wire logic lane_scan_done_i, // Lane scan result valid
    input wire logic [lnw_pkg::LNW_LANES-1:0] lane_valid_i, // Lanes with valid sets
    input wire logic cfg_done_i, // Lane-number exchange finished
    input wire logic lanenum_ok_i, // Lane-number agreement reached
    input wire lnw_pkg::lnw_width_t partner_width_i, // Width partner asked for
    input wire logic partner_reversed_i, // Partner configuration reversed
    input wire logic wchg_req_i, // Partner width change request
    input wire lnw_pkg::lnw_width_t wchg_width_i, // Requested width
    input wire logic wchg_autonomous_i, // Partner marked change autonomous
    input wire logic reliab_fail_i, // Link reliability problem seen
    output logic retrain_detect_o, // Pulse: retrain from Detect
    output lnw_pkg::lnw_width_t prop_width_o, // Proposed width
    output logic prop_reversed_o, // Proposal is reversed
    output lnw_pkg::lnw_width_t neg_width_o, // Negotiated width
    output logic lane_reversed_o, // Link formed reversed
    output logic [lnw_pkg::LNW_LANES-1:0][2:0] lane_map_o, // Logical to physical lane
    output logic down_req_o, // Pulse: reliability downsize
    output logic tx_invert_o, // Transmit inversion, held low
    output logic tx_autonomous_o, // Autonomous-change bit sent
    output logic port_merged_o // Port runs as merged x8
);
    import lnw_pkg::*;

    lnw_state_t state;
    lnw_width_t max_width_cap_field;
    lnw_width_t active_cap;
    lnw_width_t max_w;
    logic register_unlock_bit;
    logic merge_cfg;
    logic active_merged;
    logic no_rev;
    logic autonomous_bandwidth_flag;
    logic wr_cap;
    logic wr_full_retrain_bit;
    logic flag_set;
    lnw_width_t cfg_fit;
    lnw_width_t chg_fit;
    logic [31:0] next_rdata;
    lnw_width_if wif ();

    function automatic lnw_width_t fit_w(input lnw_width_t req, input lnw_width_t lim);
        if ((req == LNW_W1 || req == LNW_W2 || req == LNW_W4 || req == LNW_W8) && req <= lim) return req;
        else return LNW_W0;
    endfunction

    for (genvar g = 0; g < LNW_LANES; g++) begin : g_lane
        lnw_lane_pol u_pol (
            .clk_sys_i(clk_sys_i),
            .rst_b_i(rst_b_i),
            .sym_i(rx_sym_i[g]),
            .sym_idx_i(rx_sym_idx_i),
            .ts2_i(rx_ts2_i),
            .ts_valid_i(rx_ts_valid_i[g]),
            .training_i(training_i),
            .clear_i(detect_entry_i),
            .inv_o(rx_inv_o[g]),
            .data_o(rx_data_o[g])
        );
    end

    assign wif.lane_ok = lane_valid_i;
    assign wif.merged = active_merged;
    assign wif.cap = active_cap;

    lnw_width_calc u_calc (
        .w(wif)
    );

    assign wr_cap = reg_wr_i && reg_addr_i == LNW_OFF_LCAP && register_unlock_bit; // [RULE8]
    assign wr_full_retrain_bit = reg_wr_i && reg_addr_i == LNW_OFF_PHYLS && reg_wdata_i[LNW_FULL_RETRAIN_BIT_BIT];
    assign cfg_fit = fit_w(partner_width_i, max_w);
    assign chg_fit = fit_w(wchg_width_i, max_w);
    assign flag_set = state == ST_L0 && wchg_req_i && wchg_autonomous_i && op_downstream_i;

    // Configuration registers.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            max_width_cap_field <= LNW_MAXW_RST;
            register_unlock_bit <= LNW_UNLOCK_RST;
            merge_cfg <= LNW_MERGE_RST; // [RULE2]
        end else if (reg_wr_i) begin
            if (wr_cap) max_width_cap_field <= reg_wdata_i[LNW_MAXW_LSB +: 6]; // [RULE8]
            if (reg_addr_i == LNW_OFF_SWITCH_CONTROL_REG) register_unlock_bit <= reg_wdata_i[LNW_UNLOCK_BIT];
            if (reg_addr_i == LNW_OFF_PCFG) merge_cfg <= reg_wdata_i[LNW_MERGE_BIT]; // [RULE1]
        end
    end

    // Set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            autonomous_bandwidth_flag <= 1'b0;
        end else if (flag_set) begin
            autonomous_bandwidth_flag <= 1'b1; // [RULE20]
        end else if (reg_wr_i && reg_addr_i == LNW_OFF_LSTS && reg_wdata_i[LNW_LABW_BIT]) begin
            autonomous_bandwidth_flag <= 1'b0;
        end
    end

    // Cap and merge take effect only at a full training, so a live link keeps its shape.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_cap <= LNW_MAXW_RST;
            active_merged <= LNW_MERGE_RST;
        end else if (detect_entry_i) begin
            active_cap <= max_width_cap_field; // [RULE9]
            active_merged <= merge_cfg; // [RULE1]
        end
    end

    // Link width negotiation.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            max_w <= LNW_W0;
            prop_width_o <= LNW_W0;
            prop_reversed_o <= 1'b0;
            neg_width_o <= LNW_W0;
            lane_reversed_o <= 1'b0;
            no_rev <= 1'b0;
            retrain_detect_o <= 1'b0;
            down_req_o <= 1'b0;
        end else begin
            retrain_detect_o <= 1'b0;
            down_req_o <= 1'b0;
            if (wr_full_retrain_bit) begin
                retrain_detect_o <= 1'b1; // [RULE12]
                state <= ST_DETECT;
                neg_width_o <= LNW_W0;
            end else if (detect_entry_i) begin
                state <= ST_DETECT;
                neg_width_o <= LNW_W0;
                lane_reversed_o <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                    end
                    ST_DETECT: begin
                        if (lane_scan_done_i) begin
                            state <= ST_CONFIG;
                            if (op_downstream_i && !no_rev && wif.rev_w > wif.fwd_w) begin
                                prop_reversed_o <= 1'b1; // [RULE13] [RULE21] [RULE7]
                                prop_width_o <= wif.rev_w;
                                max_w <= wif.rev_w;
                            end else begin
                                prop_reversed_o <= 1'b0; // [RULE15]
                                prop_width_o <= wif.fwd_w; // [RULE6]
                                max_w <= wif.fwd_w;
                            end
                        end
                    end
                    ST_CONFIG: begin
                        if (cfg_done_i) begin
                            if (lanenum_ok_i && cfg_fit != LNW_W0) begin
                                state <= ST_L0;
                                neg_width_o <= cfg_fit; // [RULE10] [RULE14] [RULE11]
                                lane_reversed_o <= partner_reversed_i;
                                no_rev <= 1'b0;
                            end else begin
                                state <= ST_DETECT;
                                no_rev <= 1'b1; // [RULE15]
                                retrain_detect_o <= 1'b1;
                            end
                        end
                    end
                    ST_L0: begin
                        if (wchg_req_i && chg_fit != LNW_W0) begin
                            neg_width_o <= chg_fit; // [RULE16]
                        end else if (reliab_fail_i && neg_width_o > LNW_W1) begin
                            neg_width_o <= neg_width_o >> 1; // [RULE17]
                            down_req_o <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Lane map follows the negotiated width one cycle later.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lane_map_o <= '0;
        end else begin
            for (int i = 0; i < LNW_LANES; i++) begin
                if (lane_reversed_o && i < int'(neg_width_o)) lane_map_o[i] <= 3'(int'(neg_width_o) - 1 - i); // [RULE22]
                else lane_map_o[i] <= 3'(i);
            end
        end
    end

    // The port never signals an autonomous width change nor inverts on transmit.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_invert_o <= 1'b0;
            tx_autonomous_o <= 1'b0;
            port_merged_o <= LNW_MERGE_RST;
        end else begin
            tx_invert_o <= 1'b0; // [RULE4]
            tx_autonomous_o <= 1'b0; // [RULE19]
            port_merged_o <= active_merged;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                LNW_OFF_LCAP: next_rdata[LNW_MAXW_LSB +: 6] = max_width_cap_field;
                LNW_OFF_LCTL: next_rdata[LNW_HW_WIDTH_CHANGE_DISABLE_BIT] = 1'b0; // [RULE18]
                LNW_OFF_LSTS: begin
                    next_rdata[LNW_NLW_LSB +: 6] = neg_width_o; // [RULE11]
                    next_rdata[LNW_LABW_BIT] = autonomous_bandwidth_flag;
                end
                LNW_OFF_PHYLS: begin
                    next_rdata[LNW_STATE_LSB +: 4] = state;
                    next_rdata[LNW_NOREV_BIT] = no_rev;
                    next_rdata[LNW_REV_BIT] = lane_reversed_o;
                end
                LNW_OFF_SWITCH_CONTROL_REG: next_rdata[LNW_UNLOCK_BIT] = register_unlock_bit;
                LNW_OFF_PCFG: next_rdata[LNW_MERGE_BIT] = merge_cfg;
                LNW_OFF_POL: next_rdata[LNW_LANES-1:0] = rx_inv_o;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    lane_pol_set_a: assert property ( // [RULE3]
        training_i && rx_ts_valid_i[0] && !detect_entry_i && rx_sym_idx_i == 4'h8 && !rx_ts2_i
        && rx_sym_i[0] == ~LNW_TS1_ID |=> rx_inv_o[0] ##1 rx_data_o[0] == ~$past(rx_sym_i[0]))
        else $error("inverted TS1 symbol did not set lane inversion");
    tx_no_inv_a: assert property (tx_invert_o == 1'b0) // [RULE4]
        else $error("transmit inversion driven");
    cap_locked_a: assert property ( // [RULE8]
        reg_wr_i && reg_addr_i == LNW_OFF_LCAP && !register_unlock_bit |=> $stable(max_width_cap_field))
        else $error("cap field changed while locked");
    cap_deferred_a: assert property ( // [RULE9]
        state == ST_L0 && wr_cap && !detect_entry_i && !wchg_req_i && !reliab_fail_i && !wr_full_retrain_bit
        |=> $stable(neg_width_o) && $stable(active_cap))
        else $error("cap write altered the live link");
    full_retrain_bit_retrain_a: assert property ( // [RULE12]
        wr_full_retrain_bit |=> retrain_detect_o && state == ST_DETECT && neg_width_o == LNW_W0)
        else $error("full retrain did not go to Detect");
    lanenum_fail_a: assert property ( // [RULE15]
        state == ST_CONFIG && cfg_done_i && !lanenum_ok_i && !wr_full_retrain_bit && !detect_entry_i
        |=> retrain_detect_o && no_rev ##1 !retrain_detect_o)
        else $error("lane-number failure not retrained");
    no_rev_prop_a: assert property ( // [RULE15]
        state == ST_DETECT && lane_scan_done_i && no_rev && !wr_full_retrain_bit && !detect_entry_i |=> !prop_reversed_o)
        else $error("reversal retried after failure");
    hw_width_change_disable_zero_a: assert property ( // [RULE18]
        reg_rd_i && reg_addr_i == LNW_OFF_LCTL |=> reg_rdata_o[LNW_HW_WIDTH_CHANGE_DISABLE_BIT] == 1'b0)
        else $error("hardware width disable bit read nonzero");
    nlw_report_a: assert property ( // [RULE11]
        reg_rd_i && reg_addr_i == LNW_OFF_LSTS |=> reg_rdata_o[LNW_NLW_LSB +: 6] == $past(neg_width_o))
        else $error("negotiated width misreported");
    labw_flag_a: assert property (flag_set |=> autonomous_bandwidth_flag) // [RULE20]
        else $error("autonomous bandwidth flag not set");
    tx_auto_a: assert property (!tx_autonomous_o) // [RULE19]
        else $error("autonomous change bit transmitted");

    rev_link_c: cover property (state == ST_CONFIG && cfg_done_i && lanenum_ok_i && partner_reversed_i);
    lane_fail_c: cover property (state == ST_CONFIG && cfg_done_i && !lanenum_ok_i);
    width_chg_c: cover property (state == ST_L0 && wchg_req_i && chg_fit != LNW_W0);
    pol_inv_c: cover property (rx_inv_o[3] && !rx_inv_o[1]);
    rev_map_c: cover property (lane_reversed_o && neg_width_o == LNW_W2);
endmodule : lnw_port
`default_nettype wire

// >>> lnw_pkg.sv
`default_nettype none
package lnw_pkg;
    localparam int LNW_LANES = 8;
    localparam int LNW_QUAD = 4;
    typedef logic [5:0] lnw_width_t;
    typedef logic [7:0] lnw_addr_t;
    // Register offsets.
    localparam lnw_addr_t LNW_OFF_LCAP = 8'h00;
    localparam lnw_addr_t LNW_OFF_LCTL = 8'h04;
    localparam lnw_addr_t LNW_OFF_LSTS = 8'h08;
    localparam lnw_addr_t LNW_OFF_PHYLS = 8'h0c;
    localparam lnw_addr_t LNW_OFF_SWITCH_CONTROL_REG = 8'h10;
    localparam lnw_addr_t LNW_OFF_PCFG = 8'h14;
    localparam lnw_addr_t LNW_OFF_POL = 8'h18;
    // Field positions.
    localparam int LNW_MAXW_LSB = 4;
    localparam int LNW_HW_WIDTH_CHANGE_DISABLE_BIT = 9;
    localparam int LNW_NLW_LSB = 4;
    localparam int LNW_LABW_BIT = 15;
    localparam int LNW_FULL_RETRAIN_BIT_BIT = 0;
    localparam int LNW_STATE_LSB = 4;
    localparam int LNW_NOREV_BIT = 8;
    localparam int LNW_REV_BIT = 9;
    localparam int LNW_UNLOCK_BIT = 0;
    localparam int LNW_MERGE_BIT = 0;
    // Reset values.
    localparam lnw_width_t LNW_MAXW_RST = 6'h08;
    localparam logic LNW_MERGE_RST = 1'b0;
    localparam logic LNW_UNLOCK_RST = 1'b0;
    // Training set identifier symbols and the span checked for polarity.
    localparam logic [7:0] LNW_TS1_ID = 8'h4a;
    localparam logic [7:0] LNW_TS2_ID = 8'h45;
    localparam logic [3:0] LNW_POL_FIRST = 4'h6;
    localparam logic [3:0] LNW_POL_LAST = 4'hf;
    // Legal link widths in lanes; LNW_W0 marks no width.
    localparam lnw_width_t LNW_W0 = 6'h00;
    localparam lnw_width_t LNW_W1 = 6'h01;
    localparam lnw_width_t LNW_W2 = 6'h02;
    localparam lnw_width_t LNW_W4 = 6'h04;
    localparam lnw_width_t LNW_W8 = 6'h08;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DETECT = 4'b0010,
        ST_CONFIG = 4'b0100,
        ST_L0 = 4'b1000
    } lnw_state_t;
endpackage : lnw_pkg
`default_nettype wire

// >>> lnw_width_if.sv
`default_nettype none
interface lnw_width_if;
    import lnw_pkg::*;
    logic [LNW_LANES-1:0] lane_ok;
    logic merged;
    lnw_width_t cap;
    lnw_width_t fwd_w;
    lnw_width_t rev_w;
    modport calc (input lane_ok, input merged, input cap, output fwd_w, output rev_w);
    modport user (output lane_ok, output merged, output cap, input fwd_w, input rev_w);
endinterface : lnw_width_if
`default_nettype wire

// >>> lnw_width_calc.sv
`default_nettype none
module lnw_width_calc (
    lnw_width_if.calc w // Lane scan in, candidate widths out
);
    import lnw_pkg::*;

    function automatic lnw_width_t pow2_floor(input int c);
        if (c >= 8) return LNW_W8;
        else if (c >= 4) return LNW_W4;
        else if (c >= 2) return LNW_W2;
        else if (c >= 1) return LNW_W1;
        else return LNW_W0;
    endfunction

    always_comb begin
        int n;
        int fcnt;
        int rcnt;
        logic frun;
        logic rrun;
        lnw_width_t lim;
        n = w.merged ? LNW_LANES : LNW_QUAD;
        fcnt = 0;
        rcnt = 0;
        frun = 1'b1;
        rrun = 1'b1;
        lim = pow2_floor(int'(w.cap));
        if (!w.merged && lim > LNW_W4) begin
            lim = LNW_W4;
        end
        for (int i = 0; i < LNW_LANES; i++) begin
            if (i < n && frun && w.lane_ok[i]) fcnt++;
            else frun = 1'b0;
            if (i < n && rrun && w.lane_ok[n-1-i]) rcnt++;
            else rrun = 1'b0;
        end
        w.fwd_w = (pow2_floor(fcnt) < lim) ? pow2_floor(fcnt) : lim; // [RULE6]
        w.rev_w = (pow2_floor(rcnt) < lim) ? pow2_floor(rcnt) : lim;
    end
endmodule : lnw_width_calc
`default_nettype wire

// >>> lnw_lane_pol.sv
`default_nettype none
module lnw_lane_pol (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_b_i, // Async reset, active low
    input wire logic [7:0] sym_i, // Received symbol
    input wire logic [3:0] sym_idx_i, // Symbol index within the set
    input wire logic ts2_i, // Set is TS2 rather than TS1
    input wire logic ts_valid_i, // Symbol belongs to a training set
    input wire logic training_i, // Link is in training
    input wire logic clear_i, // Forget inversion at detect
    output logic inv_o, // Lane inversion in force
    output logic [7:0] data_o // Corrected data
);
    import lnw_pkg::*;
    logic [7:0] expect_sym;
    logic in_span;

    assign expect_sym = ts2_i ? LNW_TS2_ID : LNW_TS1_ID;
    assign in_span = sym_idx_i >= LNW_POL_FIRST && sym_idx_i <= LNW_POL_LAST;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inv_o <= 1'b0;
        end else if (clear_i) begin
            inv_o <= 1'b0;
        end else if (training_i && ts_valid_i && in_span && sym_i == ~expect_sym) begin
            inv_o <= 1'b1; // [RULE3] [RULE5]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_o <= 8'h00;
        end else begin
            data_o <= inv_o ? ~sym_i : sym_i; // [RULE3]
        end
    end
endmodule : lnw_lane_pol
`default_nettype wire

// >>> lnw_partner.sv
`default_nettype none
module lnw_partner (
    input wire logic clk_sys_i, // System clock
    input wire logic send_i, // Pulse: send one TS1 set
    input wire logic [7:0] flip_i, // Lanes wired with swapped polarity
    output logic [7:0][7:0] sym_o, // Symbols seen by the port
    output logic [3:0] idx_o, // Symbol index
    output logic ts2_o, // Set is TS2
    output logic [7:0] valid_o // Symbol belongs to a set
);
    import lnw_pkg::*;
    logic [3:0] cnt = 4'h0;
    logic busy = 1'b0;
    logic [7:0] noise = 8'h5a;
    // Outside sets the lanes keep toggling, so a stale symbol never passes for a fresh one.
    always @(posedge clk_sys_i) begin
        noise <= {noise[6:0], noise[7] ^ noise[5] ^ noise[4] ^ noise[3]};
        busy <= send_i | (busy & (cnt != 4'hf));
        cnt <= busy ? cnt + 4'h1 : 4'h0;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            sym_o[i] = busy ? ((cnt >= LNW_POL_FIRST ? LNW_TS1_ID : 8'hbc) ^ {8{flip_i[i]}}) : (noise ^ 8'(i));
        end
    end
    assign idx_o = cnt;
    assign ts2_o = 1'b0;
    assign valid_o = {8{busy}};
endmodule // lnw_partner
`default_nettype wire

// >>> test_lnw_port.sv
`default_nettype none
module test_lnw_port;
    timeunit 1ns;
    timeprecision 1ps;
    import lnw_pkg::*;
    logic clk_sys_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, rd_q = 0, training_i = 0, op_downstream_i = 1;
    logic lanenum_ok_i = 0, partner_reversed_i = 0, wchg_autonomous_i = 0, send = 0, rx_ts2_i;
    logic [4:0] ev = 5'h00;
    lnw_addr_t reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [7:0] lane_valid_i = 8'h00, rx_ts_valid_i, rx_inv_o, flip = 8'h2d;
    logic [7:0][7:0] rx_sym_i, rx_data_o, prev, expd;
    logic [7:0][2:0] lane_map_o;
    logic [3:0] rx_sym_idx_i;
    lnw_width_t partner_width_i = 6'h00, wchg_width_i = 6'h00, prop_width_o, neg_width_o, w;
    logic retrain_detect_o, prop_reversed_o, lane_reversed_o, down_req_o, tx_invert_o, tx_autonomous_o, port_merged_o;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] lfsr = 16'hd494;
    int fail_count = 0, cmp_count = 0, n;
    lnw_port u_lnw_port (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .rx_sym_i, .rx_sym_idx_i, .rx_ts2_i, .rx_ts_valid_i, .training_i, .rx_data_o, .rx_inv_o, .op_downstream_i,
        .detect_entry_i(ev[0]), .lane_scan_done_i(ev[1]), .lane_valid_i, .cfg_done_i(ev[2]), .lanenum_ok_i,
        .partner_width_i, .partner_reversed_i, .wchg_req_i(ev[3]), .wchg_width_i, .wchg_autonomous_i,
        .reliab_fail_i(ev[4]), .retrain_detect_o, .prop_width_o, .prop_reversed_o, .neg_width_o, .lane_reversed_o,
        .lane_map_o, .down_req_o, .tx_invert_o, .tx_autonomous_o, .port_merged_o);
    lnw_partner u_lnw_partner (.clk_sys_i, .send_i(send), .flip_i(flip), .sym_o(rx_sym_i), .idx_o(rx_sym_idx_i),
        .ts2_o(rx_ts2_i), .valid_o(rx_ts_valid_i));
    always #2.5 clk_sys_i = ~clk_sys_i;
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask
    task automatic wr(input lnw_addr_t a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    // The expected word is queued before the strobe; the watcher below pops it when data is due.
    task automatic rd(input lnw_addr_t a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
    endtask
    always @(posedge clk_sys_i) rd_q <= reg_rd_i;
    always @(negedge clk_sys_i) if (rd_q) chk(reg_rdata_o & msk_q.pop_front(), exp_q.pop_front());
    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        ev[k] <= 1'b1;
        @(posedge clk_sys_i);
        ev[k] <= 1'b0;
    endtask
    task automatic train(input logic [7:0] lv, input logic ok, input lnw_width_t pw, input logic rv,
        input lnw_width_t ew, input logic er);
        training_i <= 1'b1;
        pulse(0);
        send <= 1'b1;
        @(posedge clk_sys_i);
        send <= 1'b0;
        repeat (17) @(posedge clk_sys_i);
        lane_valid_i <= lv;
        lanenum_ok_i <= ok;
        partner_width_i <= pw;
        partner_reversed_i <= rv;
        pulse(1);
        @(negedge clk_sys_i);
        chk(prop_width_o, ew);
        chk(prop_reversed_o, er);
        pulse(2);
        @(negedge clk_sys_i);
        chk(retrain_detect_o, !ok);
        if (ok) chk({lane_reversed_o, neg_width_o}, {rv, pw});
        @(posedge clk_sys_i);
        training_i <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(LNW_OFF_LCAP, 32'h80, 32'h3f0);
        wr(LNW_OFF_LCTL, 32'h200);
        rd(LNW_OFF_LCTL, 32'h0, 32'h200);
        wr(LNW_OFF_LCAP, 32'h40);
        rd(LNW_OFF_LCAP, 32'h80, 32'h3f0);
        lfsr = nxt(lfsr);
        wr(8'h3c, {lfsr, lfsr});
        rd(8'h3c, 32'h0, 32'hffffffff);
        tend("registers");
        wr(LNW_OFF_SWITCH_CONTROL_REG, 32'h1);
        wr(LNW_OFF_PCFG, 32'h1);
        train(8'hff, 1'b1, LNW_W8, 1'b0, LNW_W8, 1'b0);
        chk(rx_inv_o, flip);
        chk({port_merged_o, tx_invert_o}, 2'b10);
        rd(LNW_OFF_POL, flip, 32'hff);
        rd(LNW_OFF_LSTS, 32'h80, 32'h3f0);
        repeat (4) begin
            @(negedge clk_sys_i);
            prev = rx_sym_i;
            @(negedge clk_sys_i);
            for (int i = 0; i < 8; i++) expd[i] = prev[i] ^ {8{flip[i]}};
            chk(rx_data_o[3:0], expd[3:0]);
            chk(rx_data_o[7:4], expd[7:4]);
        end
        wr(LNW_OFF_LCAP, 32'h40);
        rd(LNW_OFF_LSTS, 32'h80, 32'h3f0);
        wr(LNW_OFF_PHYLS, 32'h1);
        n = 0;
        while (retrain_detect_o !== 1'b1 && n < 5) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(n < 5, 1'b1);
        train(8'hff, 1'b1, LNW_W4, 1'b0, LNW_W4, 1'b0);
        tend("training");
        lfsr = nxt(lfsr);
        w = lfsr[0] ? LNW_W2 : LNW_W1;
        wchg_width_i <= w;
        wchg_autonomous_i <= 1'b1;
        pulse(3);
        @(negedge clk_sys_i);
        chk({tx_autonomous_o, neg_width_o}, {1'b0, w});
        rd(LNW_OFF_LSTS, 32'h8000 | (w << 4), 32'h83f0);
        wr(LNW_OFF_LSTS, 32'h8000);
        rd(LNW_OFF_LSTS, 32'h0, 32'h8000);
        pulse(4);
        @(negedge clk_sys_i);
        chk({down_req_o, neg_width_o}, {w == LNW_W2, LNW_W1});
        @(posedge clk_sys_i);
        op_downstream_i <= 1'b0;
        wchg_width_i <= LNW_W4;
        pulse(3);
        rd(LNW_OFF_LSTS, 32'h40, 32'h83f0);
        @(posedge clk_sys_i);
        op_downstream_i <= 1'b1;
        wchg_autonomous_i <= 1'b0;
        wr(LNW_OFF_PCFG, 32'h0);
        wr(LNW_OFF_LCAP, 32'h80);
        tend("dynamic width");
        train(8'h0d, 1'b1, LNW_W1, 1'b0, LNW_W2, 1'b1);
        train(8'h0d, 1'b0, LNW_W1, 1'b0, LNW_W2, 1'b1);
        train(8'h0d, 1'b1, LNW_W1, 1'b0, LNW_W1, 1'b0);
        @(negedge clk_sys_i);
        chk(lane_map_o, 24'hfac688);
        train(8'h0d, 1'b1, LNW_W2, 1'b1, LNW_W2, 1'b1);
        @(negedge clk_sys_i);
        chk(lane_map_o, 24'hfac681);
        tend("bad lanes");
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule // test_lnw_port
`default_nettype wire
